// [sim/lirc_asserts.sv]
// Port checks for the line interface reset controller
`timescale 1ns/100ps
module lirc_asserts
  import lirc_pkg::*;
#(
  parameter int unsigned POR_CYCLES = 20
)
(
  // Clock, reset and requests
  input wire logic              mclk,
  input wire logic              sys_rst,
  input wire logic              hw_rst_n,
  input wire logic              ref_clk_lost,
  input wire logic              glb_rst_wr,
  input wire logic [NUM_CH-1:0] chan_rst_wr,
  // Reset outputs
  input wire logic              common_rst,
  input wire logic              io_force_input,
  input wire logic              line_std_rst,
  input wire logic              power_down,
  input wire logic [NUM_CH-1:0] chan_rst,
  input wire logic [NUM_CH-1:0] tx_line_pin_pair_hiz,
  input wire logic [NUM_CH-1:0] rx_line_pin_pair_hiz,
  input wire logic [NUM_CH-1:0] channel_soft_reset_bit
);
  localparam int POR_LO = POR_CYCLES - 1;

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Sixteen cycles high, then low: well inside 1 us at 20 MHz
  sequence s_hold16(x);
    x[*8] ##1 x[*8] ##1 !x;
  endsequence

  soft_hold_a: assert property (glb_rst_wr && !common_rst && hw_rst_n && !ref_clk_lost
    |=> s_hold16(common_rst)) else $error("global soft reset length wrong");
  io_follow_a: assert property (io_force_input == common_rst && line_std_rst == common_rst)
    else $error("io or line standard reset not following common reset");
  hiz_map_a: assert property (tx_line_pin_pair_hiz == (chan_rst | {NUM_CH{power_down}})
    && rx_line_pin_pair_hiz == tx_line_pin_pair_hiz) else $error("line pins not floated with reset");
  common_all_a: assert property (common_rst |-> &chan_rst)
    else $error("channel left out of global reset");
  chan_pulse_a: assert property (chan_rst_wr[0] && !channel_soft_reset_bit[0] && !chan_rst[0]
    && !common_rst |=> s_hold16(channel_soft_reset_bit[0])) else $error("channel bit pulse wrong");
  chan_lag_a: assert property (!common_rst && !$past(common_rst)
    |-> chan_rst == $past(channel_soft_reset_bit)) else $error("channel reset not tracking its bit");
  pin_reset_a: assert property (!hw_rst_n |-> ##3 common_rst)
    else $error("pin low did not reset device");
  pdn_track_a: assert property (!$past(sys_rst) |-> power_down == $past(ref_clk_lost))
    else $error("power down not following clock loss");
  por_len_a: assert property ($fell(power_down) |-> ##POR_LO common_rst
    ##1 (common_rst == !$past(hw_rst_n, 3))) else $error("restart after clock loss has wrong length");
endmodule

bind lirc_reset_ctrl lirc_asserts #(.POR_CYCLES(POR_CYCLES)) u_chk (.*);

// [sim/lirc_board_model.sv]
// Board and host model: reset pin, clock monitor and reset writes
`timescale 1ns/100ps
module lirc_board_model
  import lirc_pkg::*;
(
  // Clock
  input  wire logic         mclk,
  // Requests toward the device
  output logic              hw_rst_n,
  output logic              ref_clk_lost,
  output logic              glb_rst_wr,
  output logic [NUM_CH-1:0] chan_rst_wr
);
  // Quiet levels from time zero
  initial begin
    hw_rst_n = 1'b1;
    ref_clk_lost = 1'b0;
    glb_rst_wr = 1'b0;
    chan_rst_wr = '0;
  end

  // Single write of the global reset register
  task glb();
    @(negedge mclk) glb_rst_wr = 1'b1;
    @(negedge mclk) glb_rst_wr = 1'b0;
  endtask

  // Single write of one or more channel reset bits
  task chan(input logic [NUM_CH-1:0] m);
    @(negedge mclk) chan_rst_wr = m;
    @(negedge mclk) chan_rst_wr = '0;
  endtask

  // Pin held low; callers keep it beyond 1 us
  task pin(input int n);
    @(negedge mclk) hw_rst_n = 1'b0;
    repeat (n) @(negedge mclk);
    hw_rst_n = 1'b1;
  endtask

  // Reference clock lost, then back
  task lose(input int n);
    @(negedge mclk) ref_clk_lost = 1'b1;
    repeat (n) @(negedge mclk);
    ref_clk_lost = 1'b0;
  endtask
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the line interface reset controller
`timescale 1ns/100ps
module tb_top
  import lirc_pkg::*;
;
  logic              mclk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              hw_rst_n, ref_clk_lost, glb_rst_wr, common_rst, io_in, std_rst, pdn;
  logic [NUM_CH-1:0] chan_rst_wr, chan_rst, tx_hiz, rx_hiz, ch_bit, m;
  logic [NUM_CH-1:0] prev = '0;
  logic [NUM_CH-1:0] exp_q[$];
  int                err_count = 0;
  int                checks_done = 0;
  int                k;

  // 20 MHz clock
  always #25 mclk = ~mclk;

  lirc_board_model i_host (.mclk(mclk), .hw_rst_n(hw_rst_n), .ref_clk_lost(ref_clk_lost),
    .glb_rst_wr(glb_rst_wr), .chan_rst_wr(chan_rst_wr));

  // Short power-on count keeps the run brief
  lirc_reset_ctrl #(.POR_CYCLES(20)) i_dut (.mclk(mclk), .sys_rst(sys_rst), .hw_rst_n(hw_rst_n),
    .ref_clk_lost(ref_clk_lost), .glb_rst_wr(glb_rst_wr), .chan_rst_wr(chan_rst_wr),
    .common_rst(common_rst), .io_force_input(io_in), .line_std_rst(std_rst), .power_down(pdn),
    .chan_rst(chan_rst), .tx_line_pin_pair_hiz(tx_hiz), .rx_line_pin_pair_hiz(rx_hiz),
    .channel_soft_reset_bit(ch_bit));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task tally_and_finish();
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Bounded wait until every reset has ended
  task idle();
    for (int i = 0; i < 60 && (common_rst || (|chan_rst) || (|ch_bit)); i++) @(negedge mclk);
    check({common_rst, io_in, std_rst, pdn, |chan_rst, |ch_bit, |tx_hiz, |rx_hiz}, 8'h00);
  endtask

  // Each newly reset set of channels must match the oldest note
  always @(negedge mclk) begin
    if (!sys_rst && |(chan_rst & ~prev)) begin
      check(chan_rst & ~prev, exp_q.size() ? exp_q.pop_front() : '0);
      check(tx_hiz & rx_hiz & chan_rst, chan_rst);
    end
    prev = chan_rst;
  end

  initial begin
    void'($urandom(48940));
    repeat (16) @(negedge mclk);
    sys_rst = 1'b0;
    idle();
    // Global reset, a refused rewrite mid-pulse, then back to back
    for (k = 0; k < 2; k++) begin
      exp_q.push_back('1);
      i_host.glb();
      repeat (4) @(negedge mclk);
      i_host.glb();
      idle();
    end
    // Every channel alone, rewrite while busy is ignored
    for (k = 0; k < NUM_CH; k++) begin
      m = NUM_CH'(1) << k;
      exp_q.push_back(m);
      i_host.chan(m);
      repeat (3) @(negedge mclk);
      i_host.chan(m);
      idle();
    end
    // Random group of channels at once
    m = NUM_CH'($urandom) | NUM_CH'(2);
    exp_q.push_back(m);
    i_host.chan(m);
    idle();
    // Channel pulse cut short by a global reset
    m = NUM_CH'(1) << (1 + $urandom % (NUM_CH - 1));
    exp_q.push_back(m);
    i_host.chan(m);
    repeat (3) @(negedge mclk);
    exp_q.push_back(~m);
    i_host.glb();
    idle();
    // Pin low beyond 1 us, then clock loss
    exp_q.push_back('1);
    i_host.pin(21 + $urandom % 8);
    idle();
    exp_q.push_back('1);
    i_host.lose(10);
    idle();
    // Pin held low across the restart after clock loss
    exp_q.push_back('1);
    fork
      i_host.lose(10);
      i_host.pin(50);
    join
    idle();
    check(exp_q.size(), 0);
    tally_and_finish();
  end

  // Hang guard, far beyond the expected run
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    tally_and_finish();
  end
endmodule

// [verilog/lirc_pkg.sv]
// Constants and state encoding for the line interface reset controller
package lirc_pkg;

  // Clock and channel count
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned NUM_CH        = 22;

  // Power-on reset completes within this time; longest time, rounded down
  localparam int unsigned POR_TIME_NS   = 1000000;
  localparam int unsigned POR_CYC       = POR_TIME_NS / CLK_PERIOD_NS;

  // Software resets complete within this time; longest time, rounded down
  localparam int unsigned SRST_TIME_NS  = 1000;
  localparam int unsigned SRST_CYC      = SRST_TIME_NS / CLK_PERIOD_NS;

  // Hold length of a software reset, margin left for pipeline latency
  localparam logic [4:0]  SRST_HOLD_CYC = 5'h10;

  // Counter widths
  localparam int unsigned POR_CNT_W     = 15;
  localparam int unsigned SRST_CNT_W    = 5;

  // Reset values
  localparam logic [POR_CNT_W-1:0]  POR_CNT_RST  = 15'h0000;
  localparam logic [SRST_CNT_W-1:0] SRST_CNT_RST = 5'h00;

  // Global reset sequencer states
  typedef enum logic [2:0] {
    LIRC_ST_POR  = 3'b000,
    LIRC_ST_HW   = 3'b001,
    LIRC_ST_SOFT = 3'b010,
    LIRC_ST_PDN  = 3'b011,
    LIRC_ST_RUN  = 3'b100
  } lirc_state_t;

endpackage

// [verilog/lirc_pulse_timer.sv]
// Self-timed reset pulse for one channel
`timescale 1ns/100ps
module lirc_pulse_timer
  import lirc_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Control
  input  wire logic clr,
  input  wire logic start,
  // Status
  output logic      busy
);

  logic                  busy_ff;
  logic                  nxt_busy;
  logic [SRST_CNT_W-1:0] cnt_ff;
  logic [SRST_CNT_W-1:0] nxt_cnt;

  // A start while busy is ignored; global reset aborts the pulse
  always_comb begin
    nxt_busy = busy_ff;
    nxt_cnt  = cnt_ff;
    if (clr) begin
      nxt_busy = 1'b0;
      nxt_cnt  = SRST_CNT_RST;
    end else if (busy_ff) begin
      if (cnt_ff == SRST_HOLD_CYC - 5'h01) begin
        nxt_busy = 1'b0;
        nxt_cnt  = SRST_CNT_RST;
      end else begin
        nxt_cnt  = cnt_ff + 5'h01;
      end
    end else if (start) begin
      nxt_busy = 1'b1;
      nxt_cnt  = SRST_CNT_RST;
    end
  end

  // Registers only
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busy_ff <= 1'b0;
      cnt_ff  <= SRST_CNT_RST;
    end else begin
      busy_ff <= nxt_busy;
      cnt_ff  <= nxt_cnt;
    end
  end

  assign busy = busy_ff;

endmodule

// [verilog/lirc_reset_ctrl.sv]
// Reset sequencer: power-on, pin, global soft, clock loss and per-channel resets
`timescale 1ns/100ps
module lirc_reset_ctrl
  import lirc_pkg::*;
#(
  parameter int unsigned POR_CYCLES = POR_CYC
)
(
  // Clock and power-on reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // Board reset pin and clock monitor
  input  wire logic              hw_rst_n,
  input  wire logic              ref_clk_lost,
  // Host reset requests
  input  wire logic              glb_rst_wr,
  input  wire logic [NUM_CH-1:0] chan_rst_wr,
  // Common block resets
  output logic                   common_rst,
  output logic                   io_force_input,
  output logic                   line_std_rst,
  output logic                   power_down,
  // Per-channel resets and line pin control
  output logic [NUM_CH-1:0]      chan_rst,
  output logic [NUM_CH-1:0]      tx_line_pin_pair_hiz,
  output logic [NUM_CH-1:0]      rx_line_pin_pair_hiz,
  output logic [NUM_CH-1:0]      channel_soft_reset_bit
);

  // Pin synchroniser; first stage feeds only the second
  logic hw_meta_ff;
  logic hw_sync_n_ff;
  logic nxt_hw_meta;
  logic nxt_hw_sync_n;

  // Global sequencer state
  lirc_state_t            state_ff;
  lirc_state_t            nxt_state;
  logic [POR_CNT_W-1:0]   cnt_ff;
  logic [POR_CNT_W-1:0]   nxt_cnt;

  // Registered outputs
  logic              glb_rst_ff;
  logic              nxt_glb_rst;
  logic              pdn_ff;
  logic              nxt_pdn;
  logic [NUM_CH-1:0] chan_rst_ff;
  logic [NUM_CH-1:0] nxt_chan_rst;
  logic [NUM_CH-1:0] chan_busy;

  // Terminal counts at counter width
  localparam logic [POR_CNT_W-1:0] POR_LAST  = POR_CNT_W'(POR_CYCLES - 1);
  localparam logic [POR_CNT_W-1:0] SOFT_LAST = POR_CNT_W'(SRST_HOLD_CYC - 5'h01);

  // Two-flop synchroniser of the reset pin; board holds it long enough
  always_comb begin
    nxt_hw_meta   = hw_rst_n;
    nxt_hw_sync_n = hw_meta_ff;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hw_meta_ff   <= 1'b0;
      hw_sync_n_ff <= 1'b0;
    end else begin
      hw_meta_ff   <= nxt_hw_meta;
      hw_sync_n_ff <= nxt_hw_sync_n;
    end
  end

  // Global sequencer: clock loss beats pin, pin beats soft reset
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      LIRC_ST_POR: begin
        // Counting needs mclk, so a dead clock sends the device to power-down
        if (ref_clk_lost) begin
          nxt_state = LIRC_ST_PDN;
          nxt_cnt   = POR_CNT_RST;
        end else if (cnt_ff == POR_LAST) begin
          // A pin still low takes over here, so reset never drops for a cycle
          nxt_cnt   = POR_CNT_RST;
          if (hw_sync_n_ff) begin
            nxt_state = LIRC_ST_RUN;
          end else begin
            nxt_state = LIRC_ST_HW;
          end
        end else begin
          nxt_cnt   = cnt_ff + 15'h0001;
        end
      end
      LIRC_ST_HW: begin
        // Held as long as the synchronised pin is low
        if (ref_clk_lost) begin
          nxt_state = LIRC_ST_PDN;
        end else if (hw_sync_n_ff) begin
          nxt_state = LIRC_ST_RUN;
        end
      end
      LIRC_ST_SOFT: begin
        // Fixed hold, well inside the 1 us limit
        if (ref_clk_lost) begin
          nxt_state = LIRC_ST_PDN;
          nxt_cnt   = POR_CNT_RST;
        end else if (!hw_sync_n_ff) begin
          nxt_state = LIRC_ST_HW;
          nxt_cnt   = POR_CNT_RST;
        end else if (cnt_ff == SOFT_LAST) begin
          nxt_state = LIRC_ST_RUN;
          nxt_cnt   = POR_CNT_RST;
        end else begin
          nxt_cnt   = cnt_ff + 15'h0001;
        end
      end
      LIRC_ST_PDN: begin
        // Clock back: restart with a full power-on sequence
        nxt_cnt = POR_CNT_RST;
        if (!ref_clk_lost) begin
          nxt_state = LIRC_ST_POR;
        end
      end
      LIRC_ST_RUN: begin
        nxt_cnt = POR_CNT_RST;
        if (ref_clk_lost) begin
          nxt_state = LIRC_ST_PDN;
        end else if (!hw_sync_n_ff) begin
          nxt_state = LIRC_ST_HW;
        end else if (glb_rst_wr) begin
          nxt_state = LIRC_ST_SOFT;
        end
      end
      default: begin
        nxt_state = LIRC_ST_POR;
        nxt_cnt   = POR_CNT_RST;
      end
    endcase
  end

  // Global reset is any state but run, registered so all logic leaves together
  always_comb begin
    nxt_glb_rst = (nxt_state != LIRC_ST_RUN);
    nxt_pdn     = (nxt_state == LIRC_ST_PDN);
  end

  // Sequencer registers; power-on starts in reset with global reset asserted and power-down clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_ff   <= LIRC_ST_POR;
      cnt_ff     <= POR_CNT_RST;
      glb_rst_ff <= 1'b1;
      pdn_ff     <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      glb_rst_ff <= nxt_glb_rst;
      pdn_ff     <= nxt_pdn;
    end
  end

  // One self-clearing pulse timer per channel
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_chan
      lirc_pulse_timer u_timer (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .clr     (glb_rst_ff),
        .start   (chan_rst_wr[gi]),
        .busy    (chan_busy[gi])
      );
    end
  endgenerate

  // Channel reset covers state machines, masks and registers
  always_comb begin
    nxt_chan_rst = chan_busy | {NUM_CH{nxt_glb_rst}};
  end

  // Registered so channel logic and line pins switch on one clean edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      chan_rst_ff <= {NUM_CH{1'b1}};
    end else begin
      chan_rst_ff <= nxt_chan_rst;
    end
  end

  // Line pins float for every channel in reset and while powered down
  assign tx_line_pin_pair_hiz = chan_rst_ff | {NUM_CH{pdn_ff}};
  assign rx_line_pin_pair_hiz = chan_rst_ff | {NUM_CH{pdn_ff}};

  // Bus and I/O direction follow only the global reset
  assign io_force_input = glb_rst_ff;
  // Line standard bit is not part of a channel reset
  assign line_std_rst   = glb_rst_ff;
  assign common_rst     = glb_rst_ff;
  assign power_down     = pdn_ff;
  assign chan_rst       = chan_rst_ff;
  // Reads back as one while the channel pulse runs
  assign channel_soft_reset_bit = chan_busy;

endmodule
